// [stream_dma_pkg.sv]
package stream_dma_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_IDLE   = 8'h08;
  localparam logic [7:0] OFF_FRMLEN = 8'h0c;
  localparam logic [7:0] OFF_RXHEAD = 8'h10;
  localparam logic [7:0] OFF_TXHEAD = 8'h14;
  localparam logic [7:0] OFF_MADDR  = 8'h18;
  localparam logic [7:0] OFF_MDATA  = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQEN  = 8'h24;
  localparam logic [7:0] OFF_IRQCLR = 8'h28;
  localparam logic [7:0] OFF_MBOX   = 8'h2c;
  localparam logic [7:0] OFF_STATE  = 8'h30;
  // Control register bits
  localparam int CB_RXEN   = 0;
  localparam int CB_TXEN   = 1;
  localparam int CB_COPY   = 2;
  localparam int CB_HDR    = 3;
  localparam int CB_SYNC   = 4;
  localparam int CB_FRM_LO = 5;
  localparam int CTRL_W    = 7;
  // Descriptor word 0 bits; next index in [14:0]
  localparam int DB_BRFRM   = 16;
  localparam int DB_BREARLY = 17;
  localparam int DB_STAT    = 18;
  localparam int DB_MBOX    = 19;
  localparam int DB_STOP    = 20;
  // Descriptor word 1: endpoint [15:0], branch index [30:16]
  localparam int LK_BR_LO = 16;
  localparam int IDX_W    = 15;
  localparam int EP_W     = 16;
  // Descriptor word order
  localparam logic [1:0] DW_CTRL = 2'h0;
  localparam logic [1:0] DW_LINK = 2'h1;
  localparam logic [1:0] DW_ADDR = 2'h2;
  localparam logic [1:0] DW_MAX  = 2'h3;
  // Event bits
  localparam int EV_RXDONE = 0;
  localparam int EV_EARLY  = 1;
  localparam int EV_OVFL   = 2;
  localparam int EV_MBOX   = 3;
  localparam int EV_TXDONE = 4;
  localparam int EV_STOP   = 5;
  localparam int EV_W      = 6;
  // Dispatch table of chain heads at the bottom of memory
  localparam int         DISP_BITS = 4;
  localparam logic [16:0] DISP_BASE = 17'h00000;
  // Timing and reset values
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_TIME_NS  = 4000;
  localparam int IDLE_CYC      = IDLE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [31:0] THRESH_RST = 32'h00000100;
  localparam logic [31:0] FRMLEN_RST = 32'h00000400;

  typedef enum logic [1:0] {
    FR_NONE = 2'h0, FR_SINGLE = 2'h1, FR_DYN = 2'h2, FR_FIXED = 2'h3
  } frame_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_FETCH = 3'h1, RX_WAIT = 3'h3, RX_RUN = 3'h2,
    RX_DISC = 3'h6, RX_HDR = 3'h7, RX_STAT = 3'h5, RX_DONE = 3'h4
  } rx_st_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_FETCH = 3'h1, TX_WAIT = 3'h3, TX_RUN = 3'h2,
    TX_DONE = 3'h6
  } tx_st_t;
endpackage : stream_dma_pkg

// [frame_driven_stream_dma.sv]
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// How it works
// - Four framing modes: none, single, dynamic, fixed
// - Epoch header word indexes chain head table
// - Descriptor may branch at frame end
// - Early frame end follows programmed branch
// - Each epoch end restarts descriptor alignment
// - Max word count caps buffer writes
// - Drain starts when FIFO exceeds threshold
// - Idle timeout drains leftover FIFO data
// - Separate transmit and receive engines run concurrently
// - Optional transmit gating by receive activity
// - Copy mode retransmits every received word
// - Descriptor may emit status block write
// - Descriptor may raise mailbox interrupt
// - Local descriptor memory, 128K by 32
// - Walk and link descriptors autonomously
// - Descriptor holds endpoint, address, count, control
// - Counters and addresses are 32 bits
module frame_driven_stream_dma
  import stream_dma_pkg::*;
#(
  parameter int MEM_WORDS = 131072,
  parameter int LVL_W     = 15
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [7:0]       avsAddress,
  input  wire logic             avsRead,
  input  wire logic             avsWrite,
  input  wire logic [31:0]      avsWriteData,
  output logic      [31:0]      avsReadData,
  output logic                  avsWaitRequest,
  input  wire logic [31:0]      inData,
  input  wire logic             inEnd,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [LVL_W-1:0] inLevel,
  input  wire logic             inArrive,
  output logic      [31:0]      wrData,
  output logic      [EP_W-1:0]  wrEndpoint,
  output logic      [31:0]      wrAddr,
  output logic                  wrStatus,
  output logic                  wrValid,
  input  wire logic             wrReady,
  input  wire logic [31:0]      txSrcData,
  input  wire logic             txSrcValid,
  output logic                  txSrcReady,
  output logic      [EP_W-1:0]  txSrcEndpoint,
  output logic      [31:0]      txSrcAddr,
  output logic      [31:0]      linkData,
  output logic                  linkValid,
  input  wire logic             linkReady,
  output logic                  irq
);
  localparam int MA_W = $clog2(MEM_WORDS);

  // Software state
  logic [CTRL_W-1:0] ctrl_q;        // Enables and modes
  logic [31:0]       thresh_q;      // FIFO drain threshold
  logic [31:0]       idle_q;        // Idle timeout in cycles
  logic [31:0]       frmLen_q;      // Fixed frame length in words
  logic [IDX_W-1:0]  rxHead_q;      // Receive chain start
  logic [IDX_W-1:0]  txHead_q;      // Transmit chain start
  logic [MA_W-1:0]   mAddr_q;       // Memory window pointer
  logic [EV_W-1:0]   status_q;      // Sticky events
  logic [EV_W-1:0]   irqEn_q;       // Interrupt enables
  logic [IDX_W-1:0]  mailbox_q;     // Last mailbox descriptor
  frame_t            frMode;
  assign frMode = frame_t'(ctrl_q[CB_FRM_LO+1:CB_FRM_LO]);

  // Descriptor memory and shared read port
  logic [31:0]     dmem [MEM_WORDS];
  logic [31:0]     memQ;
  logic [MA_W-1:0] rdAddr;
  logic            gRx, gTx, gBus;

  // Bus phase: 0 idle, 1 reg or mem write ack, 2 mem read data, 3 mem read ack
  logic [1:0] ph_q;
  logic       busReq, isMem, ackNow, busWr;

  // Receive engine
  rx_st_t           rxSt_q;
  logic [31:0]      rxDesc_q [4];
  logic [1:0]       rxWord_q;
  logic [IDX_W-1:0] rxIdx_q, rxNext_q;
  logic             rxTbl_q;        // Fetch reads dispatch table
  logic [DISP_BITS-1:0] hdrIdx_q;
  logic [31:0]      rxCnt_q, rxA_q, frm_q, epochs_q;
  rx_st_t           rxAfter_q;      // State after status write
  logic [EV_W-1:0]  rxEv_q;
  logic             rxTake, rxFull, endHere, rxFin, finEnd, early;
  logic             goDisc, rxBranch;
  logic [IDX_W-1:0] rxPick;
  logic             drain_q;
  logic [31:0]      idleCnt_q;

  // Transmit engine
  tx_st_t           txSt_q;
  logic [31:0]      txDesc_q [4];
  logic [1:0]       txWord_q;
  logic [IDX_W-1:0] txIdx_q;
  logic [31:0]      txCnt_q;
  logic [EV_W-1:0]  txEv_q;
  logic             txTake, txFull;

  logic wrFree, linkFree, copyOn;

  // Chooses the branch or the plain link of a descriptor
  function automatic logic [IDX_W-1:0] pickIdx(
    input logic [31:0] c, input logic [31:0] lk, input logic br);
    pickIdx = br ? lk[LK_BR_LO+IDX_W-1:LK_BR_LO] : c[IDX_W-1:0];
  endfunction : pickIdx

  // Register read decode
  function automatic logic [31:0] regRead(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    if (a == OFF_CTRL) r[CTRL_W-1:0] = ctrl_q;
    else if (a == OFF_THRESH) r = thresh_q;
    else if (a == OFF_IDLE) r = idle_q;
    else if (a == OFF_FRMLEN) r = frmLen_q;
    else if (a == OFF_RXHEAD) r[IDX_W-1:0] = rxHead_q;
    else if (a == OFF_TXHEAD) r[IDX_W-1:0] = txHead_q;
    else if (a == OFF_MADDR) r[MA_W-1:0] = mAddr_q;
    else if (a == OFF_STATUS) r[EV_W-1:0] = status_q;
    else if (a == OFF_IRQEN) r[EV_W-1:0] = irqEn_q;
    else if (a == OFF_MBOX) r[IDX_W-1:0] = mailbox_q;
    else if (a == OFF_STATE) begin
      r[2:0]   = rxSt_q;
      r[6:4]   = txSt_q;
      r[8]     = drain_q;
      r[31:16] = rxCnt_q[15:0];
    end
    regRead = r;
  endfunction : regRead

  // Handshake terms
  assign wrFree   = !wrValid || wrReady;
  assign linkFree = !linkValid || linkReady;
  assign copyOn   = ctrl_q[CB_COPY];
  assign rxFull   = rxCnt_q >= rxDesc_q[DW_MAX];
  // Receive accepts only while draining; copy needs the link too
  assign inReady  = drain_q && (!copyOn || linkFree) &&
                    ((rxSt_q == RX_RUN && wrFree && !rxFull) ||
                     rxSt_q == RX_HDR || rxSt_q == RX_DISC);
  assign rxTake   = inValid && inReady;
  assign txFull   = txCnt_q >= txDesc_q[DW_MAX];
  // Copy traffic has the link first; sync holds tx until rx runs
  assign txSrcReady = txSt_q == TX_RUN && !txFull && linkFree &&
                      !(copyOn && inValid) &&
                      (!ctrl_q[CB_SYNC] || rxSt_q == RX_RUN);
  assign txTake   = txSrcValid && txSrcReady;

  // Frame end detection per framing mode
  always_comb begin
    endHere = inEnd && frMode != FR_NONE;
    if (frMode == FR_FIXED && frm_q + 32'h1 >= frmLen_q)
      endHere = 1'b1;
  end

  // Completion decisions of the receive descriptor
  always_comb begin
    finEnd   = rxTake && endHere &&
               ((rxSt_q == RX_RUN && !rxFull) || rxSt_q == RX_DISC);
    goDisc   = rxSt_q == RX_RUN && rxFull && frMode != FR_NONE;
    rxFin    = finEnd || (rxSt_q == RX_RUN && rxFull && frMode == FR_NONE);
    early    = rxSt_q == RX_RUN &&
               rxCnt_q + 32'h1 < rxDesc_q[DW_MAX];
    rxBranch = finEnd && (rxDesc_q[DW_CTRL][DB_BRFRM] ||
                          (early && rxDesc_q[DW_CTRL][DB_BREARLY]));
    rxPick   = pickIdx(rxDesc_q[DW_CTRL], rxDesc_q[DW_LINK], rxBranch);
  end

  // Memory read arbitration: receive, then transmit, then bus
  assign busReq = avsRead || avsWrite;
  assign isMem  = avsAddress == OFF_MDATA;
  assign gRx    = rxSt_q == RX_FETCH;
  assign gTx    = txSt_q == TX_FETCH && !gRx;
  assign gBus   = ph_q == 2'h0 && avsRead && isMem && !gRx && !gTx;
  always_comb begin
    if (gRx && rxTbl_q)
      rdAddr = MA_W'(DISP_BASE) + MA_W'(hdrIdx_q);
    else if (gRx)
      rdAddr = MA_W'({rxIdx_q, rxWord_q});
    else if (gTx)
      rdAddr = MA_W'({txIdx_q, txWord_q});
    else
      rdAddr = mAddr_q;
  end

  // Descriptor memory: bus writes, one shared read port
  always_ff @(posedge clock) begin
    if (busWr && isMem)
      dmem[mAddr_q] <= avsWriteData;
    memQ <= dmem[rdAddr];
  end

  // Bus handshake; a read waits for its data flop
  assign ackNow         = ph_q == 2'h1 || ph_q == 2'h3;
  assign avsWaitRequest = busReq && !ackNow;
  assign busWr          = ackNow && avsWrite;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_q        <= 2'h0;
      avsReadData <= 32'h0;
    end else begin
      case (ph_q)
        2'h0: begin
          if (gBus) begin
            ph_q <= 2'h2;
          end else if (busReq && !(avsRead && isMem)) begin
            ph_q        <= 2'h1;
            avsReadData <= regRead(avsAddress);
          end
        end
        2'h2: begin
          ph_q        <= 2'h3;
          avsReadData <= memQ;
        end
        default: ph_q <= 2'h0;
      endcase
    end
  end

  // Configuration registers, written at the acknowledge edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q   <= '0;
      thresh_q <= THRESH_RST;
      idle_q   <= 32'(IDLE_CYC);
      frmLen_q <= FRMLEN_RST;
      rxHead_q <= '0;
      txHead_q <= '0;
      irqEn_q  <= '0;
      mAddr_q  <= '0;
    end else begin
      if (busWr) begin
        if (avsAddress == OFF_CTRL) ctrl_q <= avsWriteData[CTRL_W-1:0];
        else if (avsAddress == OFF_THRESH) thresh_q <= avsWriteData;
        else if (avsAddress == OFF_IDLE) idle_q <= avsWriteData;
        else if (avsAddress == OFF_FRMLEN) frmLen_q <= avsWriteData;
        else if (avsAddress == OFF_RXHEAD) rxHead_q <= avsWriteData[IDX_W-1:0];
        else if (avsAddress == OFF_TXHEAD) txHead_q <= avsWriteData[IDX_W-1:0];
        else if (avsAddress == OFF_IRQEN) irqEn_q <= avsWriteData[EV_W-1:0];
        else if (avsAddress == OFF_MADDR) mAddr_q <= avsWriteData[MA_W-1:0];
      end
      // Window pointer steps after each data access
      if (ackNow && isMem)
        mAddr_q <= mAddr_q + MA_W'(1);
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      if (busWr && avsAddress == OFF_IRQCLR)
        status_q <= (status_q & ~avsWriteData[EV_W-1:0]) | rxEv_q | txEv_q;
      else
        status_q <= status_q | rxEv_q | txEv_q;
    end
  end
  assign irq = |(status_q & irqEn_q);

  // Drain control: threshold or idle timeout
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idleCnt_q <= '0;
      drain_q   <= 1'b0;
    end else begin
      // Any arrival restarts the idle count
      if (inArrive || inLevel == '0)
        idleCnt_q <= '0;
      else if (idleCnt_q < idle_q)
        idleCnt_q <= idleCnt_q + 32'h1;
      if (32'(inLevel) > thresh_q)
        drain_q <= 1'b1;
      else if (inLevel != '0 && idleCnt_q >= idle_q)
        drain_q <= 1'b1;
      else if (inLevel == '0)
        drain_q <= 1'b0;
    end
  end

  // Receive engine: walks its chain without software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxSt_q    <= RX_IDLE;
      rxWord_q  <= 2'h0;
      rxIdx_q   <= '0;
      rxNext_q  <= '0;
      rxTbl_q   <= 1'b0;
      hdrIdx_q  <= '0;
      rxCnt_q   <= '0;
      rxA_q     <= '0;
      frm_q     <= '0;
      epochs_q  <= '0;
      rxAfter_q <= RX_IDLE;
      rxEv_q    <= '0;
      mailbox_q <= '0;
      for (int i = 0; i < 4; i++) rxDesc_q[i] <= '0;
    end else begin
      rxEv_q <= '0;
      case (rxSt_q)
        RX_IDLE: begin
          if (ctrl_q[CB_RXEN]) begin
            rxIdx_q  <= rxHead_q;
            rxWord_q <= 2'h0;
            frm_q    <= '0;
            rxSt_q   <= ctrl_q[CB_HDR] ? RX_HDR : RX_FETCH;
          end
        end
        RX_FETCH: rxSt_q <= RX_WAIT;
        RX_WAIT: begin
          if (rxTbl_q) begin
            rxIdx_q <= memQ[IDX_W-1:0];
            rxTbl_q <= 1'b0;
            rxSt_q  <= RX_FETCH;
          end else begin
            rxDesc_q[rxWord_q] <= memQ;
            rxWord_q <= rxWord_q + 2'h1;
            if (rxWord_q == DW_ADDR) rxA_q <= memQ;
            if (rxWord_q == DW_MAX) begin
              rxCnt_q <= '0;
              rxSt_q  <= RX_RUN;
            end else begin
              rxSt_q <= RX_FETCH;
            end
          end
        end
        RX_HDR: begin
          // Header word picks the chain, then is dropped
          if (rxTake) begin
            hdrIdx_q <= inData[DISP_BITS-1:0];
            rxTbl_q  <= 1'b1;
            rxWord_q <= 2'h0;
            frm_q    <= frm_q + 32'h1;
            rxSt_q   <= RX_FETCH;
          end
        end
        RX_RUN: begin
          if (goDisc) begin
            rxEv_q[EV_OVFL] <= 1'b1;
            rxSt_q <= RX_DISC;
          end else if (rxTake) begin
            rxCnt_q <= rxCnt_q + 32'h1;
            rxA_q   <= rxA_q + 32'h4;
            frm_q   <= frm_q + 32'h1;
          end
        end
        RX_DISC: begin
          // Excess words are dropped until the epoch ends
          if (rxTake) frm_q <= frm_q + 32'h1;
        end
        RX_STAT: if (wrFree) rxSt_q <= rxAfter_q;
        default: if (!ctrl_q[CB_RXEN]) rxSt_q <= RX_IDLE;
      endcase
      // Descriptor completion overrides the per-state moves
      if (rxFin) begin
        rxEv_q[EV_RXDONE] <= 1'b1;
        if (early && finEnd) rxEv_q[EV_EARLY] <= 1'b1;
        if (rxDesc_q[DW_CTRL][DB_MBOX]) begin
          rxEv_q[EV_MBOX] <= 1'b1;
          mailbox_q <= rxIdx_q;
        end
        rxIdx_q  <= rxPick;
        rxNext_q <= rxPick;
        rxWord_q <= 2'h0;
        if (finEnd) begin
          frm_q    <= '0;
          epochs_q <= epochs_q + 32'h1;
        end
        if (rxDesc_q[DW_CTRL][DB_STOP]) begin
          rxEv_q[EV_STOP] <= 1'b1;
          rxAfter_q <= RX_DONE;
        end else if (finEnd && frMode == FR_SINGLE) begin
          rxAfter_q <= RX_DONE;
        end else if (finEnd && ctrl_q[CB_HDR]) begin
          rxAfter_q <= RX_HDR;
        end else begin
          rxAfter_q <= RX_FETCH;
        end
        if (rxDesc_q[DW_CTRL][DB_STAT])
          rxSt_q <= RX_STAT;
        else if (rxDesc_q[DW_CTRL][DB_STOP] ||
                 (finEnd && frMode == FR_SINGLE))
          rxSt_q <= RX_DONE;
        else if (finEnd && ctrl_q[CB_HDR])
          rxSt_q <= RX_HDR;
        else
          rxSt_q <= RX_FETCH;
      end
    end
  end

  // Destination write port: data words and status blocks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrValid    <= 1'b0;
      wrData     <= '0;
      wrAddr     <= '0;
      wrEndpoint <= '0;
      wrStatus   <= 1'b0;
    end else if (wrFree) begin
      wrValid <= 1'b0;
      if (rxSt_q == RX_RUN && rxTake) begin
        wrValid    <= 1'b1;
        wrData     <= inData;
        wrAddr     <= rxA_q;
        wrEndpoint <= rxDesc_q[DW_LINK][EP_W-1:0];
        wrStatus   <= 1'b0;
      end else if (rxSt_q == RX_STAT) begin
        wrValid    <= 1'b1;
        wrData     <= {epochs_q[15:0], rxCnt_q[15:0]};
        wrAddr     <= rxA_q;
        wrEndpoint <= rxDesc_q[DW_LINK][EP_W-1:0];
        wrStatus   <= 1'b1;
      end
    end
  end

  // Transmit engine, independent of receive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txSt_q    <= TX_IDLE;
      txWord_q  <= 2'h0;
      txIdx_q   <= '0;
      txCnt_q   <= '0;
      txSrcAddr <= '0;
      txEv_q    <= '0;
      for (int i = 0; i < 4; i++) txDesc_q[i] <= '0;
    end else begin
      txEv_q <= '0;
      case (txSt_q)
        TX_IDLE: begin
          if (ctrl_q[CB_TXEN]) begin
            txIdx_q  <= txHead_q;
            txWord_q <= 2'h0;
            txSt_q   <= TX_FETCH;
          end
        end
        TX_FETCH: if (gTx) txSt_q <= TX_WAIT;
        TX_WAIT: begin
          txDesc_q[txWord_q] <= memQ;
          txWord_q <= txWord_q + 2'h1;
          if (txWord_q == DW_ADDR) txSrcAddr <= memQ;
          if (txWord_q == DW_MAX) begin
            txCnt_q <= '0;
            txSt_q  <= TX_RUN;
          end else begin
            txSt_q <= TX_FETCH;
          end
        end
        TX_RUN: begin
          if (txFull) begin
            txEv_q[EV_TXDONE] <= 1'b1;
            txWord_q <= 2'h0;
            txIdx_q  <= pickIdx(txDesc_q[DW_CTRL], txDesc_q[DW_LINK], 1'b0);
            if (txDesc_q[DW_CTRL][DB_STOP]) begin
              txEv_q[EV_STOP] <= 1'b1;
              txSt_q <= TX_DONE;
            end else begin
              txSt_q <= TX_FETCH;
            end
          end else if (txTake) begin
            txCnt_q   <= txCnt_q + 32'h1;
            txSrcAddr <= txSrcAddr + 32'h4;
          end
        end
        default: if (!ctrl_q[CB_TXEN]) txSt_q <= TX_IDLE;
      endcase
    end
  end
  assign txSrcEndpoint = txDesc_q[DW_LINK][EP_W-1:0];

  // Link output: copied receive words first, else transmit data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      linkValid <= 1'b0;
      linkData  <= '0;
    end else if (linkFree) begin
      linkValid <= 1'b0;
      if (copyOn && rxTake) begin
        linkValid <= 1'b1;
        linkData  <= inData;
      end else if (txTake) begin
        linkValid <= 1'b1;
        linkData  <= txSrcData;
      end
    end
  end
endmodule : frame_driven_stream_dma

// [stream_dma_asserts.sv]
`timescale 1ns/10ps
// Port-level checks; only the top ports are visible
module stream_dma_checker
  import stream_dma_pkg::*;
#(
  parameter int MEM_WORDS = 131072,
  parameter int LVL_W     = 15
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             avsRead,
  input wire logic             avsWrite,
  input wire logic             avsWaitRequest,
  input wire logic             inValid,
  input wire logic             inReady,
  input wire logic [LVL_W-1:0] inLevel,
  input wire logic [31:0]      wrData,
  input wire logic [31:0]      wrAddr,
  input wire logic             wrStatus,
  input wire logic             wrValid,
  input wire logic             wrReady,
  input wire logic             txSrcValid,
  input wire logic             txSrcReady,
  input wire logic [31:0]      linkData,
  input wire logic             linkValid,
  input wire logic             linkReady
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Ack lasts one cycle, then a new request waits again
  ack_release_a: assert property ((avsRead || avsWrite) && !avsWaitRequest |=>
    !(avsRead || avsWrite) || avsWaitRequest) else $error("Ack held too long");
  idle_nowait_a: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
    else $error("Wait without request");
  // Bound covers memory reads behind descriptor fetches
  answer_bound_a: assert property ((avsRead || avsWrite) |-> ##[0:40] !avsWaitRequest)
    else $error("Bus answer missing");
  // Drain register may lag an empty FIFO by one cycle
  drain_level_a: assert property (inReady |-> inLevel != 0 || $past(inLevel) != 0)
    else $error("Drain with empty FIFO");
  wr_hold_a: assert property (wrValid && !wrReady |=> wrValid && $stable(wrData) &&
    $stable(wrAddr)) else $error("Write dropped or changed");
  link_hold_a: assert property (linkValid && !linkReady |=>
    linkValid && $stable(linkData)) else $error("Link word dropped or changed");
  wr_cause_a: assert property ($rose(wrValid) |-> wrStatus || $past(inValid && inReady))
    else $error("Write without input word");
  link_cause_a: assert property ($rose(linkValid) |-> $past(inValid && inReady) ||
    $past(txSrcValid && txSrcReady)) else $error("Link word without source");
  cover property (inValid && inReady);
  cover property (txSrcValid && txSrcReady);
  cover property (wrValid && wrReady);
  cover property (linkValid && linkReady);
endmodule : stream_dma_checker

bind frame_driven_stream_dma stream_dma_checker #(.MEM_WORDS(MEM_WORDS), .LVL_W(LVL_W)) i_chk (.*);

// [sensor_source_model.sv]
`timescale 1ns/10ps
// Sensor side: input FIFO filled word by word by the bench
module sensor_source_model #(
  parameter int LVL_W = 15
) (
  input  wire logic             clock,
  input  wire logic             inReady,
  output logic      [31:0]      inData = 32'h0,
  output logic                  inEnd = 1'b0,
  output logic                  inValid = 1'b0,
  output logic      [LVL_W-1:0] inLevel = '0,
  output logic                  inArrive = 1'b0
);
  logic [32:0] q[$];           // Words with end flag
  logic        arrived = 1'b0; // Set by push, seen once
  // One word per cycle at most
  task push(input logic [31:0] d, input logic e);
    q.push_back({e, d});
    arrived = 1'b1;
  endtask : push
  // Pop on take, then present the new head registered
  always @(posedge clock) begin
    if (inValid && inReady) begin
      void'(q.pop_front());
    end
    inArrive <= arrived;
    arrived = 1'b0;
    inValid <= q.size() != 0;
    inLevel <= LVL_W'(q.size());
    // Empty FIFO shows a changing value, never a stale word
    {inEnd, inData} <= (q.size() != 0) ? q[0] : ~{inEnd, inData};
  end
endmodule : sensor_source_model

// [tb_frame_driven_stream_dma.sv]
`timescale 1ns/10ps
module tb_frame_driven_stream_dma;
  import stream_dma_pkg::*;
  localparam int LVL_W = 15;
  logic clock = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, txSrcValid = 1'b0;
  logic wrReady = 1'b0, linkReady = 1'b0, avsWaitRequest, inEnd, inValid, inReady, inArrive;
  logic wrStatus, wrValid, txSrcReady, linkValid, irq;
  logic [7:0] avsAddress = 8'h00;
  logic [31:0] avsWriteData = 32'h0, txSrcData = 32'h0, avsReadData, inData, wrData, wrAddr;
  logic [31:0] linkData, txSrcAddr, r, word;
  logic [31:0] desc[4] = '{32'h0, 32'h5, 32'h1000, 32'h4}; // Self-loop, endpoint 5
  logic [31:0] tdesc[4] = '{32'h1, 32'h7, 32'h2000, 32'h2}; // Transmit self-loop at index 1
  logic [LVL_W-1:0] inLevel;
  logic [EP_W-1:0] wrEndpoint, txSrcEndpoint;
  logic [63:0] ew, expWr[$];
  logic [31:0] expLink[$];
  int fails = 0, comparisons = 0, seed = 32'h9a80, n, nWr = 0, k;

  frame_driven_stream_dma #(.MEM_WORDS(1024), .LVL_W(LVL_W)) i_dut (.*);
  sensor_source_model #(.LVL_W(LVL_W)) i_src (.*);

  always #5 clock = ~clock;
  // Random stalls on both sinks
  always @(posedge clock) begin
    wrReady <= 1'($random(seed));
    linkReady <= 1'($random(seed));
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // One Avalon access; waitrequest and read data taken at the rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 50);
    r = avsReadData;
    if (k == 50) fails++;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // Idle cycle so a following call never reassigns in this time step
    @(posedge clock);
  endtask : bus

  // Compare every write and link word with the model
  always @(posedge clock) begin
    if (wrValid && wrReady) begin
      ew = expWr.pop_front();
      check(wrData, ew[31:0]);
      check(wrAddr, ew[63:32]);
      check({wrStatus, wrEndpoint}, 32'h5);
      nWr++;
    end
    if (linkValid && linkReady) check(linkData, expLink.pop_front());
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(0, OFF_THRESH, 0); check(r, THRESH_RST);
    bus(0, OFF_FRMLEN, 0); check(r, FRMLEN_RST);
    bus(1, 8'h40, 32'hffffffff); bus(0, 8'h40, 0); check(r, 32'h0);
    bus(1, OFF_THRESH, 32'h8); bus(0, OFF_THRESH, 0); check(r, 32'h8);
    bus(1, OFF_IDLE, 32'h4);
    bus(1, OFF_MADDR, 0);
    foreach (desc[i]) bus(1, OFF_MDATA, desc[i]);
    bus(1, OFF_MADDR, 0);
    foreach (desc[i]) begin bus(0, OFF_MDATA, 0); check(r, desc[i]); end
    bus(1, OFF_RXHEAD, 0);
    bus(1, OFF_IRQEN, 32'h1);
    bus(1, OFF_CTRL, 32'h5); // Receive with copy
    // Six words: below threshold, and past one descriptor
    for (n = 0; n < 6; n++) begin
      word = $random(seed);
      i_src.push(word, 1'b0);
      expWr.push_back({32'h1000 + 32'(4 * (n % 4)), word});
      expLink.push_back(word);
      @(posedge clock);
    end
    check(nWr, 0);
    // Transmit chain of two-word descriptors; waits while copy owns the link
    bus(1, OFF_MADDR, 32'h4);
    foreach (tdesc[i]) bus(1, OFF_MDATA, tdesc[i]);
    bus(1, OFF_TXHEAD, 32'h1);
    bus(1, OFF_CTRL, 32'h7);
    for (n = 0; n < 4; n++) begin
      word = $random(seed);
      txSrcData <= word;
      txSrcValid <= 1'b1;
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (txSrcReady !== 1'b1 && k < 200);
      if (k == 200) fails++;
      check(txSrcAddr, 32'h2000 + 32'(4 * (n % 2)));
      check(txSrcEndpoint, 32'h7);
      expLink.push_back(word);
    end
    txSrcValid <= 1'b0;
    for (n = 0; n < 2000 && (expWr.size() + expLink.size()) != 0; n++) @(posedge clock);
    if (n == 2000) fails++;
    @(negedge clock); check(irq, 1'b1);
    bus(1, OFF_IRQEN, 0); @(negedge clock); check(irq, 1'b0);
    bus(0, OFF_STATUS, 0); check(r[EV_RXDONE], 1'b1);
    check(r[EV_TXDONE], 1'b1);
    bus(1, OFF_IRQCLR, 32'h1);
    bus(0, OFF_STATUS, 0); check(r[EV_RXDONE], 1'b0);
    conclude();
  end
endmodule : tb_frame_driven_stream_dma
